// ---- dol_pkg.sv ----
// shared constants, codes and symbol functions for the dual link board
// assumes one 25 MHz reference clock for all logic
package dol_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ     = 25_000_000;
   localparam int unsigned CLK_NS     = 40;
   localparam int unsigned POR_MS     = 100;
   localparam int unsigned POR_CYC    = CLK_HZ / 1000 * POR_MS;
   localparam int unsigned NPULSE_NS  = 21;
   localparam int unsigned NPULSE_RAW = (NPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned NPULSE_CYC = (NPULSE_RAW < 1) ? 1 : NPULSE_RAW;
   localparam logic [1:0]  DIV3_LAST  = 2'h2;

   // structure
   localparam int unsigned NIB_W  = 6;
   localparam int unsigned WORD_W = 10;
   localparam int unsigned SYM_W  = 12;
   localparam int unsigned LANES  = 4;
   localparam int unsigned LINKS  = 2;
   localparam int unsigned CHANS  = 256;

   // bit phases within one nibble period
   localparam logic [2:0] BIT_LAST = 3'h5;
   localparam logic [2:0] BIT_RXCAP = 3'h0;
   localparam logic [2:0] BIT_NIB  = 3'h1;
   localparam logic [2:0] BIT_DRV  = 3'h2;
   localparam logic [2:0] BIT_CAP  = 3'h3;

   // control symbol codes
   localparam logic [4:0] CODE_FRAME = 5'h00;
   localparam logic [2:0] CODE_ALARM = 3'h1;
   localparam int unsigned CODE_SIDE = 4;
   localparam logic [9:0] PRBS_SEED  = 10'h3FF;

   typedef enum logic [2:0] {
      MODE_PAYLOAD = 3'b001,
      MODE_ALARM   = 3'b010,
      MODE_PRBS    = 3'b100
   } dol_mode_e;

   // register offsets
   localparam logic [3:0] REG_PAGE    = 4'h0;
   localparam logic [3:0] REG_CTRL    = 4'h1;
   localparam logic [3:0] REG_STAT    = 4'h2;
   localparam logic [3:0] REG_SIDE_TX = 4'h3;
   localparam logic [3:0] REG_SIDE_RX = 4'h4;
   localparam logic [3:0] REG_CVOLT   = 4'h5;
   localparam logic [3:0] REG_CLK     = 4'h6;
   localparam logic [3:0] REG_LOOP    = 4'h7;

   // field layout and reset values
   localparam int unsigned CTRL_ALM_LSB = 3;
   localparam logic [4:0]  CTRL_RST     = 5'h01;
   localparam logic [7:0]  LOOP_RST     = 8'h00;
   localparam logic [11:0] CV_RST       = 12'h800;

   function automatic logic [11:0] dol_enc(input logic [9:0] w);
      return {1'b1, w[9:5], 1'b0, w[4:0]};
   endfunction

   function automatic logic [11:0] dol_ctl(input logic [4:0] c);
      return {1'b0, c, 1'b1, ~c};
   endfunction

   function automatic logic [9:0] dol_prbs(input logic [9:0] s);
      return {s[8:0], s[9] ^ s[6]};
   endfunction

   localparam logic [11:0] FRAME_SYM = dol_ctl(CODE_FRAME);

endpackage

// ---- dol_estore.sv ----
// one-frame elastic store: one write port, one read port, registered read
// assumes write and read run on the same clock
`timescale 1ns/1ps
module dol_estore
   import dol_pkg::*;
   #(parameter int unsigned DW = WORD_W,
     parameter int unsigned DEPTH = CHANS,
     parameter int unsigned AW = $clog2(DEPTH))
   (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // write side
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // read side
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
   );

   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] rdata_q;

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[raddr];
      end
   end

   assign rdata = rdata_q;

endmodule

// ---- dol_link_board.sv ----
// dual optical link board logic: serializer lanes, two link codecs,
// subrate controller with processor registers, clock dividers, power-up reset
// assumes serial inputs asynchronous; shared bus and processor bus on ref_clk
`timescale 1ns/1ps

// Behaviour
// RQ1: custom logic held in reset at least 100 ms after power-up.
// RQ2: each serial input recovered and presented as 6-bit parallel nibbles.
// RQ3: remote loopback sends each received serial input back out its output.
// RQ4: four 6-bit parallel buses serialized onto four independent serial outputs.
// RQ5: local loopback feeds each serial output back into its own input.
// RQ6: codec decodes received twelve-bit symbols back into 10-bit words.
// RQ7: received words buffered in a one-frame elastic store.
// RQ8: last received alarm code latched and kept after the alarm ends.
// RQ9: received test sequence checked and pattern correctness reported.
// RQ10: codec drives shared receive lines only in its own slots.
// RQ11: codec captures shared transmit lines only in its own slots.
// RQ12: captured transmit words encoded into twelve-bit symbols.
// RQ13: on command, payload replaced by alarm codes or test sequence.
// RQ14: frame word sent whenever the transmit frame pulse occurs.
// RQ15: each symbol split into two 6-bit nibbles, sent in sequence.
// RQ16: codec control and state held in processor read/write registers.
// RQ17: subrate timing lets both codecs share one shared bus.
// RQ18: side-channel messages buffered on receive and sendable on both links.
// RQ19: processor addresses decoded, page setting selects codec registers.
// RQ20: reference frame pulse generated from a received link.
// RQ21: divide-by-three clock derived, then divide-by-two from it.
// RQ22: narrow frame pulse derived from the reference frame pulse.
// RQ23: bus slots alternate between link 0 and link 1.
// RQ24: 12-bit control voltage held unchanged until rewritten.
module dol_link_board
   import dol_pkg::*;
   #(parameter int unsigned POR_CYCLES = POR_CYC,
     parameter int unsigned CH_N = CHANS)
   (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   // serial lanes
   input  wire logic [LANES-1:0]       ser_rx_in,
   output logic      [LANES-1:0]       ser_tx_out,
   // spare lanes 2 and 3
   input  wire logic [2*NIB_W-1:0]     aux_tx_nib,
   output logic      [2*NIB_W-1:0]     aux_rx_nib,
   output logic                        aux_nib_stb,
   // shared bus
   input  wire logic [WORD_W-1:0]      shared_bus_transmit_data,
   output logic      [WORD_W-1:0]      shared_bus_receive_data,
   output logic      [LINKS-1:0]       shared_bus_receive_oe_n,
   output logic                        bus_frame_pulse,
   output logic      [LINKS-1:0]       link_select,
   output logic                        link_strobe,
   // processor bus
   input  wire logic                   pbus_sel,
   input  wire logic                   pbus_wr,
   input  wire logic [3:0]             pbus_addr,
   input  wire logic [15:0]            pbus_wdata,
   output logic      [15:0]            pbus_rdata,
   output logic                        pbus_ack,
   // clock section
   output logic                        ref_frame_pulse,
   output logic                        narrow_frame_pulse,
   output logic                        clk_div3,
   output logic                        clk_div2,
   output logic      [11:0]            cv_value,
   output logic                        asic_reset_n
   );

   localparam int unsigned SLOT_W = $clog2(2 * CH_N);
   localparam int unsigned CH_W   = SLOT_W - 1;
   localparam int unsigned PW     = $clog2(POR_CYCLES + 1);
   localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(2 * CH_N - 1);

   // reset release and power-up hold
   logic [1:0]    rst_q;
   logic [PW-1:0] por_cnt_q;
   logic          por_done_q;
   wire           rst_n   = rst_q[1];
   wire           por_end = por_cnt_q == PW'(POR_CYCLES);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_cnt_q  <= '0;
         por_done_q <= 1'b0;
      end else begin
         if (!por_end) begin
            por_cnt_q <= por_cnt_q + 1'b1;
         end
         por_done_q <= por_end; // [RQ1]
      end
   end
   assign asic_reset_n = por_done_q;

   // subrate timing: bit within nibble, bus slot within frame
   logic [2:0]        bit_q;
   logic [SLOT_W-1:0] slot_q;
   wire               nib_end = bit_q == BIT_LAST;
   wire               nib_stb = bit_q == BIT_NIB;
   wire               owner   = slot_q[0];
   wire [CH_W-1:0]    chan    = slot_q[SLOT_W-1:1];
   wire               tx_fp   = nib_end & (slot_q == SLOT_LAST);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_q  <= 3'h0;
         slot_q <= '0;
      end else begin
         bit_q <= nib_end ? 3'h0 : bit_q + 3'h1;
         if (nib_end) begin
            slot_q <= (slot_q == SLOT_LAST) ? '0 : slot_q + 1'b1; // [RQ23]
         end
      end
   end

   assign bus_frame_pulse = (slot_q == '0) & (bit_q == 3'h0); // [RQ17]
   assign link_select     = {owner, ~owner}; // [RQ23]
   assign link_strobe     = bit_q == BIT_CAP;
   assign aux_nib_stb     = nib_stb;

   // processor registers
   logic                   page_q;
   logic                   refsel_q;
   logic [7:0]             loop_q;
   logic [11:0]            cv_q;
   logic [LINKS-1:0][4:0]  ctrl_q;
   logic [15:0]            rdata_q;
   logic                   ack_q;
   wire  [15:0]            stat_w [LINKS];
   wire  [3:0]             side_w [LINKS];
   wire  [WORD_W-1:0]      rd_w [LINKS];
   wire  [LINKS-1:0]       rx_fp_w;
   wire  [NIB_W-1:0]       tx_nib_w [LANES];
   wire  [NIB_W-1:0]       rx_nib_w [LANES];

   wire             wr      = pbus_sel & pbus_wr;
   wire             rd      = pbus_sel & ~pbus_wr;
   wire [LINKS-1:0] pg      = {page_q, ~page_q};
   wire [LINKS-1:0] side_set = {LINKS{wr & (pbus_addr == REG_SIDE_TX)}} & pg;
   wire [LINKS-1:0] side_clr = {LINKS{rd & (pbus_addr == REG_SIDE_RX)}} & pg;
   wire [LINKS-1:0] stat_clr = {LINKS{wr & (pbus_addr == REG_STAT)}} & pg;
   wire             cv_wr    = wr & (pbus_addr == REG_CVOLT);
   // page selects which codec the paged offsets reach
   wire [15:0] rd_val =
      (pbus_addr == REG_PAGE)    ? {15'h0, page_q} :
      (pbus_addr == REG_CTRL)    ? {11'h0, ctrl_q[page_q]} :
      (pbus_addr == REG_STAT)    ? stat_w[page_q] :
      (pbus_addr == REG_SIDE_RX) ? {12'h0, side_w[page_q]} :
      (pbus_addr == REG_CVOLT)   ? {4'h0, cv_q} :
      (pbus_addr == REG_CLK)     ? {15'h0, refsel_q} :
      (pbus_addr == REG_LOOP)    ? {8'h0, loop_q} : 16'h0; // [RQ19]

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_q   <= 1'b0;
         refsel_q <= 1'b0;
         loop_q   <= LOOP_RST;
         cv_q     <= CV_RST;
         ctrl_q   <= {LINKS{CTRL_RST}};
         rdata_q  <= 16'h0;
         ack_q    <= 1'b0;
      end else begin
         ack_q <= pbus_sel;
         if (rd) begin
            rdata_q <= rd_val; // [RQ16]
         end
         if (wr && pbus_addr == REG_PAGE) begin
            page_q <= pbus_wdata[0]; // [RQ19]
         end
         if (wr && pbus_addr == REG_CTRL) begin
            ctrl_q[page_q] <= pbus_wdata[4:0]; // [RQ16]
         end
         if (wr && pbus_addr == REG_CLK) begin
            refsel_q <= pbus_wdata[0];
         end
         if (wr && pbus_addr == REG_LOOP) begin
            loop_q <= pbus_wdata[7:0];
         end
         if (cv_wr) begin
            cv_q <= pbus_wdata[11:0]; // [RQ24]
         end
      end
   end
   assign pbus_rdata = rdata_q;
   assign pbus_ack   = ack_q;
   assign cv_value   = cv_q;

   // serializer lanes
   assign tx_nib_w[2] = aux_tx_nib[NIB_W-1:0];
   assign tx_nib_w[3] = aux_tx_nib[2*NIB_W-1:NIB_W];
   assign aux_rx_nib  = {rx_nib_w[3], rx_nib_w[2]};

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [NIB_W-1:0] tx_sh_q, rx_sh_q, nib_q;
      logic             meta_q, sync_q, out_q;
      wire              rbit = loop_q[LANES+g] ? out_q : sync_q; // [RQ5]

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q  <= 1'b0;
            sync_q  <= 1'b0;
            out_q   <= 1'b0;
            tx_sh_q <= '0;
            rx_sh_q <= '0;
            nib_q   <= '0;
         end else begin
            meta_q  <= ser_rx_in[g];
            sync_q  <= meta_q;
            tx_sh_q <= nib_end ? tx_nib_w[g] : {tx_sh_q[NIB_W-2:0], 1'b0}; // [RQ4]
            out_q   <= loop_q[g] ? sync_q : tx_sh_q[NIB_W-1]; // [RQ3]
            rx_sh_q <= {rx_sh_q[NIB_W-2:0], rbit};
            if (bit_q == BIT_RXCAP) begin
               nib_q <= {rx_sh_q[NIB_W-2:0], rbit}; // [RQ2]
            end
         end
      end
      assign ser_tx_out[g] = out_q;
      assign rx_nib_w[g]   = nib_q;
   end

   // link codecs
   for (genvar i = 0; i < LINKS; i++) begin : g_link
      logic [SYM_W-1:0]  sym_q;
      logic [WORD_W-1:0] word_q, lfsr_q, rlfsr_q;
      logic [3:0]        side_tx_q, side_rx_q;
      logic [NIB_W-1:0]  prev_q;
      logic [1:0]        alm_q;
      logic [CH_W-1:0]   wcnt_q;
      logic side_pend_q, phase_q, framed_q, viol_q, pok_q, perr_q, side_vld_q;

      wire [2:0] mode = ctrl_q[i][2:0];
      wire [1:0] alm  = ctrl_q[i][CTRL_ALM_LSB+1:CTRL_ALM_LSB];
      wire mine    = owner == 1'(i);
      wire build   = nib_end & owner;
      wire side_go = build & side_pend_q & (chan == '0) & ~tx_fp;
      wire [SYM_W-1:0] pay =
         (mode == MODE_ALARM) ? dol_ctl({CODE_ALARM, alm}) :
         (mode == MODE_PRBS)  ? dol_enc(lfsr_q) : dol_enc(word_q); // [RQ12] [RQ13]
      wire [SYM_W-1:0] nsym = tx_fp ? FRAME_SYM :
         side_go ? dol_ctl({1'b1, side_tx_q}) : pay; // [RQ14] [RQ18]
      // high nibble leaves first, low nibble one slot later
      assign tx_nib_w[i] = build ? nsym[SYM_W-1:NIB_W] : sym_q[NIB_W-1:0]; // [RQ15]

      wire [SYM_W-1:0]  cand    = {prev_q, rx_nib_w[i]};
      wire              is_fr   = cand == FRAME_SYM;
      wire              sym_stb = nib_stb & (is_fr | phase_q);
      wire              is_dat  = cand[11] & ~cand[5];
      wire              is_ctl  = ~cand[11] & cand[5] & (cand[10:6] == ~cand[4:0]);
      wire [4:0]        code    = cand[10:6];
      wire [WORD_W-1:0] rword   = {cand[10:6], cand[4:0]}; // [RQ6]
      wire              dat_stb = sym_stb & is_dat;
      wire              side_in = sym_stb & is_ctl & code[CODE_SIDE];
      wire              alm_in  = sym_stb & is_ctl & (code[4:2] == CODE_ALARM);
      wire              bad     = sym_stb & ~is_dat & ~is_ctl;
      wire              pmatch  = rword == dol_prbs(rlfsr_q);

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            sym_q <= FRAME_SYM;
            word_q <= '0;
            lfsr_q <= PRBS_SEED;
            rlfsr_q <= '0;
            side_tx_q <= 4'h0;
            side_rx_q <= 4'h0;
            side_pend_q <= 1'b0;
            side_vld_q <= 1'b0;
            prev_q <= '0;
            phase_q <= 1'b0;
            framed_q <= 1'b0;
            wcnt_q <= '0;
            alm_q <= 2'h0;
            viol_q <= 1'b0;
            pok_q <= 1'b0;
            perr_q <= 1'b0;
         end else begin
            if (build) begin
               sym_q <= nsym;
            end
            // sequence only advances when a test word is really sent
            if (build && mode == MODE_PRBS && !tx_fp && !side_go) begin
               lfsr_q <= dol_prbs(lfsr_q); // [RQ13]
            end
            if (mine && bit_q == BIT_CAP) begin
               word_q <= shared_bus_transmit_data; // [RQ11]
            end
            if (side_set[i]) begin
               side_tx_q <= pbus_wdata[3:0];
            end
            side_pend_q <= side_set[i] | (side_pend_q & ~side_go); // [RQ18]
            if (nib_stb) begin
               prev_q  <= rx_nib_w[i];
               phase_q <= ~(is_fr | phase_q);
            end
            if (sym_stb && is_fr) begin
               wcnt_q   <= '0;
               framed_q <= 1'b1;
            end else if (dat_stb) begin
               wcnt_q <= wcnt_q + 1'b1;
            end else if (bad) begin
               framed_q <= 1'b0;
            end
            if (dat_stb) begin
               rlfsr_q <= rword;
               pok_q   <= pmatch; // [RQ9]
            end
            perr_q <= (dat_stb & ~pmatch) | (perr_q & ~stat_clr[i]); // [RQ9]
            viol_q <= bad | (viol_q & ~stat_clr[i]);
            if (alm_in) begin
               alm_q <= code[1:0]; // [RQ8]
            end
            if (side_in) begin
               side_rx_q <= code[3:0];
            end
            side_vld_q <= side_in | (side_vld_q & ~side_clr[i]); // [RQ18]
         end
      end

      dol_estore #(.DW(WORD_W), .DEPTH(CH_N), .AW(CH_W)) u_estore (
         .clk   (ref_clk),
         .rst_n (rst_n),
         .we    (dat_stb),
         .waddr (wcnt_q),
         .wdata (rword),
         .raddr (chan),
         .rdata (rd_w[i])
      ); // [RQ7]

      assign stat_w[i] = {9'h0, side_vld_q, viol_q, framed_q, perr_q, pok_q, alm_q}; // [RQ16]
      assign side_w[i] = side_rx_q;
      assign rx_fp_w[i] = sym_stb & is_fr;
      assign shared_bus_receive_oe_n[i] =
         ~(mine & framed_q & por_done_q & (bit_q >= BIT_DRV)); // [RQ10]
   end

   // shared receive data, reference pulse, narrow pulse, dividers
   logic [WORD_W-1:0] srd_q;
   logic              ref_fp_q;
   logic [3:0]        np_cnt_q;
   logic [1:0]        d3_q;
   logic              div3_q, div2_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         srd_q    <= '0;
         ref_fp_q <= 1'b0;
         np_cnt_q <= 4'h0;
         d3_q     <= 2'h0;
         div3_q   <= 1'b0;
         div2_q   <= 1'b0;
      end else begin
         srd_q    <= rd_w[owner];
         ref_fp_q <= rx_fp_w[refsel_q]; // [RQ20]
         if (ref_fp_q) begin
            np_cnt_q <= 4'(NPULSE_CYC); // [RQ22]
         end else if (np_cnt_q != 4'h0) begin
            np_cnt_q <= np_cnt_q - 4'h1;
         end
         d3_q   <= (d3_q == DIV3_LAST) ? 2'h0 : d3_q + 2'h1;
         div3_q <= d3_q == DIV3_LAST; // [RQ21]
         div2_q <= div2_q ^ (d3_q == DIV3_LAST); // [RQ21]
      end
   end
   assign shared_bus_receive_data = srd_q;
   assign ref_frame_pulse    = ref_fp_q;
   assign narrow_frame_pulse = np_cnt_q != 4'h0;
   assign clk_div3           = div3_q;
   assign clk_div2           = div2_q;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_POR_HOLD: assert property (!por_end |-> ##1 !asic_reset_n) // [RQ1]
      else $error("reset released before hold time");
   AST_RLOOP: assert property (loop_q[2] |=> ser_tx_out[2] == $past(g_lane[2].sync_q)) // [RQ3]
      else $error("remote loopback not applied");
   AST_TX_SER: assert property ((nib_end && !loop_q[2]) ##1 !loop_q[2] |=> // [RQ4]
      ser_tx_out[2] == $past(aux_tx_nib[5], 2))
      else $error("serial output not first nibble bit");
   AST_FRAME_WORD: assert property (tx_fp |=> g_link[0].sym_q == FRAME_SYM) // [RQ14]
      else $error("frame word not sent on frame pulse");
   AST_BUS_RELEASE: assert property (owner |-> shared_bus_receive_oe_n[0]) // [RQ10]
      else $error("link 0 drives bus outside its slot");
   AST_CAPTURE: assert property (!(owner && bit_q == BIT_CAP) |=> $stable(g_link[1].word_q)) // [RQ11]
      else $error("link 1 captured outside its slot");
   AST_ALARM_HOLD: assert property (!g_link[0].alm_in |=> $stable(g_link[0].alm_q)) // [RQ8]
      else $error("latched alarm changed");
   AST_NARROW: assert property (ref_fp_q |=> narrow_frame_pulse ##1 !narrow_frame_pulse) // [RQ22]
      else $error("narrow pulse width wrong");
   AST_DIV3: assert property ($rose(clk_div3) |=> !clk_div3 ##1 !clk_div3 ##1 clk_div3) // [RQ21]
      else $error("divide by three period wrong");
   AST_INTERLEAVE: assert property ((link_select == 2'b01 && nib_end) |=> link_select == 2'b10) // [RQ23]
      else $error("slots do not alternate");
   AST_CV_HOLD: assert property (!cv_wr |=> $stable(cv_value)) // [RQ24]
      else $error("control voltage changed without write");

   COV_RX_FRAME: cover property (rx_fp_w[0] ##[1:8] ref_frame_pulse);
   COV_SIDE_RX:  cover property (g_link[1].side_in);
   COV_PRBS_OK:  cover property (g_link[0].dat_stb && g_link[0].pmatch);

endmodule

// ---- dol_card_model.sv ----
// far-side message card model: drives shared transmit words per slot
// assumes slot strobe and select come from the board on ref_clk
`timescale 1ns/1ps
module dol_card_model
   import dol_pkg::*;
   (
   // clock
   input  wire logic              clk,
   // slot timing
   input  wire logic [LINKS-1:0]  link_select,
   input  wire logic              link_strobe,
   // shared bus
   output logic      [WORD_W-1:0] tx_word
   );
   initial tx_word = 10'h155;
   // new word just after each capture edge, held until the next strobe
   always @(posedge clk) begin
      if (link_strobe) begin
         tx_word <= {link_select[1], tx_word[8:0] + 9'h001};
      end
   end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the dual link board
// assumes card model on the shared bus, fibre model on the serial lanes
`timescale 1ns/1ps
module tb_top;
   import dol_pkg::*;
   localparam int unsigned POR_N = 20;
   logic              ref_clk = 1'b0;
   logic              rstn = 1'b0;
   logic [LANES-1:0]  ser_rx_in = 4'h0, ser_tx_out, far_pat = 4'h0;
   logic              far_inv = 1'b0;
   logic [11:0]       aux_tx_nib = 12'hFC0, aux_rx_nib, cv_value;
   logic [WORD_W-1:0] stx, srx;
   logic [LINKS-1:0]  oe_n, link_select;
   logic              aux_nib_stb, bus_frame_pulse, link_strobe, pbus_ack, rfp, nfp, clk_div3, clk_div2, arst_n;
   logic              pbus_sel = 1'b0, pbus_wr = 1'b0;
   logic [3:0]        pbus_addr = 4'h0;
   logic [15:0]       pbus_wdata = 16'h0, pbus_rdata, rd;
   int                miscompares = 0, cmp_count = 0;
   always #20 ref_clk = ~ref_clk;
   // fibre: inverted loop back, or a fixed level per lane
   always @(posedge ref_clk) ser_rx_in <= far_inv ? ~ser_tx_out : far_pat;
   dol_card_model card_u (.clk(ref_clk), .link_select(link_select), .link_strobe(link_strobe), .tx_word(stx));
   dol_link_board #(.POR_CYCLES(POR_N), .CH_N(4)) dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .ser_rx_in(ser_rx_in), .ser_tx_out(ser_tx_out),
      .aux_tx_nib(aux_tx_nib), .aux_rx_nib(aux_rx_nib), .aux_nib_stb(aux_nib_stb),
      .shared_bus_transmit_data(stx), .shared_bus_receive_data(srx), .shared_bus_receive_oe_n(oe_n),
      .bus_frame_pulse(bus_frame_pulse), .link_select(link_select), .link_strobe(link_strobe),
      .pbus_sel(pbus_sel), .pbus_wr(pbus_wr), .pbus_addr(pbus_addr), .pbus_wdata(pbus_wdata),
      .pbus_rdata(pbus_rdata), .pbus_ack(pbus_ack), .ref_frame_pulse(rfp), .narrow_frame_pulse(nfp),
      .clk_div3(clk_div3), .clk_div2(clk_div2), .cv_value(cv_value), .asic_reset_n(arst_n));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pbus(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge ref_clk);
      pbus_sel <= 1'b1;
      pbus_wr <= wr;
      pbus_addr <= a;
      pbus_wdata <= d;
      @(posedge ref_clk);
      pbus_sel <= 1'b0;
      #1 chk("ack", {15'h0, pbus_ack}, 16'h1);
      q = pbus_rdata;
   endtask
   task automatic t_por();
      int n;
      n = 0;
      while (arst_n !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk("por_len", {15'h0, n >= POR_N + 2}, 16'h1);
      chk("por_done", {15'h0, arst_n}, 16'h1);
   endtask
   task automatic t_regs();
      logic [2:0] md [3] = '{3'h1, 3'h2, 3'h4};
      pbus(1'b1, REG_CVOLT, 16'hFABC, rd);
      pbus(1'b1, REG_PAGE, 16'h0001, rd);
      pbus(1'b0, REG_PAGE, 16'h0, rd);
      chk("page", rd, 16'h0001);
      for (int i = 0; i < 3; i++) begin
         pbus(1'b1, REG_CTRL, {11'h0, 2'(i), md[i]}, rd);
         pbus(1'b0, REG_CTRL, 16'h0, rd);
         chk("ctrl", rd, {11'h0, 2'(i), md[i]});
      end
      pbus(1'b1, 4'h9, 16'hFFFF, rd);
      pbus(1'b0, 4'h9, 16'h0, rd);
      chk("unmapped", rd, 16'h0);
      pbus(1'b0, REG_CVOLT, 16'h0, rd);
      chk("cv_read", rd, 16'h0ABC);
      chk("cv_out", {4'h0, cv_value}, 16'h0ABC);
   endtask
   task automatic t_div();
      int h, t;
      logic p;
      h = 0;
      t = 0;
      p = clk_div2;
      repeat (12) begin
         @(posedge ref_clk);
         #1 h += int'(clk_div3);
         t += int'(clk_div2 !== p);
         p = clk_div2;
      end
      chk("div3", 16'(h), 16'h4);
      chk("div2", 16'(t), 16'h4);
   endtask
   task automatic t_slot();
      int n;
      n = 0;
      while (bus_frame_pulse !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         #1 n++;
      end
      for (int k = 0; k < 24; k++) begin
         chk("select", {14'h0, link_select}, ((k / 6) % 2) ? 16'h2 : 16'h1);
         chk("strobe", {15'h0, link_strobe}, {15'h0, k % 6 == 3});
         chk("oe_n", {14'h0, oe_n}, 16'h3);
         @(posedge ref_clk);
         #1;
      end
   endtask
   task automatic t_lanes(input logic [7:0] lp, input logic inv, input logic [3:0] pat, input logic [11:0] exp);
      pbus(1'b1, REG_LOOP, {8'h0, lp}, rd);
      far_inv <= inv;
      far_pat <= pat;
      repeat (60) @(posedge ref_clk);
      #1;
      while (aux_nib_stb !== 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
      chk("rx_nib", {4'h0, aux_rx_nib}, {4'h0, exp});
      chk("tx_lane2", {15'h0, ser_tx_out[2]}, {15'h0, lp[2] ? pat[2] : 1'b0});
   endtask
   task automatic t_ref();
      int r, f, o;
      r = 0;
      f = 0;
      o = 0;
      pbus(1'b1, REG_CLK, 16'h0001, rd);
      repeat (50) @(posedge ref_clk);
      pbus(1'b1, REG_STAT, 16'h0, rd);
      while (bus_frame_pulse !== 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
      repeat (96) begin
         r += int'(rfp === 1'b1);
         f += int'(nfp === 1'b1);
         o += int'(oe_n === 2'b01);
         @(posedge ref_clk);
         #1;
      end
      chk("ref_fp", 16'(r), 16'h2);
      chk("narrow_fp", 16'(f), 16'h2);
      chk("oe_n_link1", 16'(o), 16'h20);
      pbus(1'b0, REG_STAT, 16'h0, rd);
      chk("stat_link1", {12'h0, rd[5:2]}, 16'h5);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #(6000 * 40);
      miscompares++;
      results();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 chk("rst_oe_n", {14'h0, oe_n}, 16'h3);
      chk("rst_cv", {4'h0, cv_value}, 16'h0800);
      chk("rst_asic", {15'h0, arst_n}, 16'h0);
      chk("rst_srx", {6'h0, srx}, 16'h0);
      @(posedge ref_clk);
      rstn <= 1'b1;
      t_por();
      t_regs();
      t_div();
      t_slot();
      t_lanes(8'h00, 1'b1, 4'h0, 12'h03F);
      t_lanes(8'hF0, 1'b1, 4'h0, 12'hFC0);
      t_ref();
      t_lanes(8'h04, 1'b0, 4'h4, 12'h03F);
      t_lanes(8'h04, 1'b0, 4'h0, 12'h000);
      results();
   end
endmodule
